// ==== bert_consts.vh ====
`ifndef BERT_CONSTS_VH
`define BERT_CONSTS_VH

// ==========================================================
// Register offsets on the host port
`define BERT_ADDR_W 5
`define BERT_ADDR_TAP 5'h03
`define BERT_ADDR_SEED0 5'h04
`define BERT_ADDR_SEED1 5'h05
`define BERT_ADDR_SEED2 5'h06
`define BERT_ADDR_SEED3 5'h07
`define BERT_ADDR_EIC 5'h08
`define BERT_ADDR_LIVE 5'h0C
`define BERT_ADDR_LATCHED 5'h0E

// ==========================================================
// Reset values
`define BERT_REG_RESET 8'h00
`define BERT_SEED_RESET 32'h00000000

// ==========================================================
// Field positions
`define BERT_TAP_MSB 4
`define BERT_RATE_MSB 5
`define BERT_RATE_LSB 3
`define BERT_SINGLE_EN_BIT 2
`define BERT_SOFT_INS_BIT 1
`define BERT_SRC_SEL_BIT 0
`define BERT_ST_UPDATE_BIT 3
`define BERT_ST_BITERR_BIT 2
`define BERT_ST_COUNT_BIT 1
`define BERT_ST_SYNC_BIT 0

// ==========================================================
// Sizes
`define BERT_SEED_W 32
`define BERT_INTERVAL_W 24

`endif

// ==== tx_skid_buffer.v ====
`timescale 1ns/100ps

// ==========================================================
// Two-entry buffer; both handshake outputs come from flops
module tx_skid_buffer #(
    parameter WIDTH = 2
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] head_ff;
    reg [WIDTH-1:0] tail_ff;
    reg head_vld_ff;
    reg tail_vld_ff;
    wire push;
    wire pop;

    assign push = i_in_valid & ~tail_vld_ff;
    assign pop = head_vld_ff & i_out_ready;
    assign o_in_ready = ~tail_vld_ff;
    assign o_out_valid = head_vld_ff;
    assign o_out_data = head_ff;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            head_ff <= {WIDTH{1'b0}};
            tail_ff <= {WIDTH{1'b0}};
            head_vld_ff <= 1'b0;
            tail_vld_ff <= 1'b0;
        end else if (pop && push) begin
            head_ff <= i_in_data;
        end else if (pop) begin
            head_ff <= tail_ff;
            head_vld_ff <= tail_vld_ff;
            tail_vld_ff <= 1'b0;
        end else if (push) begin
            if (!head_vld_ff) begin
                head_ff <= i_in_data;
                head_vld_ff <= 1'b1;
            end else begin
                tail_ff <= i_in_data;
                tail_vld_ff <= 1'b1;
            end
        end
    end
endmodule

// ==== prbs_pattern_gen.v ====
`timescale 1ns/100ps

// ==========================================================
// Pattern shift register; stage k is state_ff[k-1]
module prbs_pattern_gen #(
    parameter SEED_W = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_load,
    input wire i_advance,
    input wire [SEED_W-1:0] i_seed,
    input wire [4:0] i_length,
    input wire [4:0] i_tap,
    input wire i_repetitive,
    output wire o_bit
);
    reg [SEED_W-1:0] state_ff;
    wire stage_n;
    wire stage_y;
    wire feedback;

    // Field value plus one selects the stage, so the index is the field itself
    assign stage_n = state_ff[i_length];
    assign stage_y = state_ff[i_tap];
    // Repetitive mode loops stage n back and never looks at the tap
    assign feedback = i_repetitive ? stage_n : (stage_n ^ stage_y);
    // With length 32 the first bit out is seed bit 31
    assign o_bit = stage_n;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= {SEED_W{1'b0}};
        end else if (i_load) begin
            state_ff <= i_seed;
        end else if (i_advance) begin
            state_ff <= {state_ff[SEED_W-2:0], feedback};
        end
    end
endmodule

// ==== bert_pattern_error_status.v ====
`timescale 1ns/100ps
`include "bert_consts.vh"

module bert_pattern_error_status #(
    parameter SEED_W = 32,
    parameter INTERVAL_W = 24
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [4:0] i_addr,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata_ff,
    input wire [4:0] i_pattern_length,
    input wire i_pattern_repetitive,
    input wire i_tx_pattern_load,
    input wire i_update_source_mode,
    input wire i_local_monitor_update,
    input wire i_ext_monitor_update_in,
    input wire i_monitor_update_complete,
    input wire i_rx_bit_error,
    input wire i_error_count_nonzero,
    input wire i_out_of_sync,
    input wire i_ext_error_insert_in,
    input wire i_tx_bit_en,
    input wire i_tx_ready,
    output wire o_tx_valid,
    output wire o_tx_data,
    output wire o_tx_error_marked,
    output wire [SEED_W-1:0] o_seed_pattern_word,
    output wire [4:0] o_tap_select_field
);

    // ==========================================================
    // Host registers
    reg [4:0] tap_select_field_ff;
    reg [7:0] seed_pattern_byte0_ff;
    reg [7:0] seed_pattern_byte1_ff;
    reg [7:0] seed_pattern_byte2_ff;
    reg [7:0] seed_pattern_byte3_ff;
    reg [2:0] error_rate_exponent_ff;
    reg single_error_enable_ff;
    reg soft_error_insert_ff;
    reg insert_source_select_ff;
    wire [SEED_W-1:0] seed_pattern_word;
    wire wr_eic;

    assign wr_eic = i_wr_en && (i_addr == `BERT_ADDR_EIC);
    assign seed_pattern_word = {seed_pattern_byte3_ff, seed_pattern_byte2_ff,
                                seed_pattern_byte1_ff, seed_pattern_byte0_ff};
    assign o_seed_pattern_word = seed_pattern_word;
    assign o_tap_select_field = tap_select_field_ff;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tap_select_field_ff <= 5'h00;
            seed_pattern_byte0_ff <= `BERT_REG_RESET;
            seed_pattern_byte1_ff <= `BERT_REG_RESET;
            seed_pattern_byte2_ff <= `BERT_REG_RESET;
            seed_pattern_byte3_ff <= `BERT_REG_RESET;
            error_rate_exponent_ff <= 3'h0;
            single_error_enable_ff <= 1'b0;
            soft_error_insert_ff <= 1'b0;
            insert_source_select_ff <= 1'b0;
        end else if (i_wr_en) begin
            case (i_addr)
                `BERT_ADDR_TAP: tap_select_field_ff <= i_wdata[`BERT_TAP_MSB:0];
                `BERT_ADDR_SEED0: seed_pattern_byte0_ff <= i_wdata;
                `BERT_ADDR_SEED1: seed_pattern_byte1_ff <= i_wdata;
                `BERT_ADDR_SEED2: seed_pattern_byte2_ff <= i_wdata;
                `BERT_ADDR_SEED3: seed_pattern_byte3_ff <= i_wdata;
                `BERT_ADDR_EIC: begin
                    error_rate_exponent_ff <= i_wdata[`BERT_RATE_MSB:`BERT_RATE_LSB];
                    single_error_enable_ff <= i_wdata[`BERT_SINGLE_EN_BIT];
                    soft_error_insert_ff <= i_wdata[`BERT_SOFT_INS_BIT];
                    insert_source_select_ff <= i_wdata[`BERT_SRC_SEL_BIT];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Transmit pattern generator and output buffer
    reg load_d_ff;
    wire gen_bit;
    wire buf_ready;
    wire advance;
    wire tx_bit;
    wire tx_err;
    wire gen_load;

    // Stalled receiver holds back the generator, so slots offered while the buffer is full are dropped but no pattern bit is skipped
    assign advance = i_tx_bit_en & buf_ready;
    assign gen_load = i_tx_pattern_load & ~load_d_ff;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            load_d_ff <= 1'b0;
        end else begin
            load_d_ff <= i_tx_pattern_load;
        end
    end

    prbs_pattern_gen #(
        .SEED_W(SEED_W)
    ) u_gen (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(gen_load),
        .i_advance(advance),
        .i_seed(seed_pattern_word),
        .i_length(i_pattern_length),
        .i_tap(tap_select_field_ff),
        .i_repetitive(i_pattern_repetitive),
        .o_bit(gen_bit)
    );

    tx_skid_buffer #(
        .WIDTH(2)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_tx_bit_en),
        .o_in_ready(buf_ready),
        .i_in_data({tx_bit, tx_err}),
        .o_out_valid(o_tx_valid),
        .i_out_ready(i_tx_ready),
        .o_out_data({o_tx_data, o_tx_error_marked})
    );

    // ==========================================================
    // Rate-based insertion
    reg [2:0] active_rate_ff;
    reg [2:0] pending_rate_ff;
    reg [INTERVAL_W-1:0] interval_cnt_ff;
    wire [INTERVAL_W-1:0] interval_last;
    wire rate_hit;

    // Last bit index of an interval of ten-to-the-n bits
    function [INTERVAL_W-1:0] last_index;
        input [2:0] exp_n;
        begin
            case (exp_n)
                3'h1: last_index = 24'h000009;
                3'h2: last_index = 24'h000063;
                3'h3: last_index = 24'h0003E7;
                3'h4: last_index = 24'h00270F;
                3'h5: last_index = 24'h01869F;
                3'h6: last_index = 24'h0F423F;
                3'h7: last_index = 24'h98967F;
                default: last_index = 24'h000000;
            endcase
        end
    endfunction

    assign interval_last = last_index(active_rate_ff);
    assign rate_hit = (active_rate_ff != 3'h0) && (interval_cnt_ff == interval_last);

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            active_rate_ff <= 3'h0;
            pending_rate_ff <= 3'h0;
            interval_cnt_ff <= {INTERVAL_W{1'b0}};
        end else begin
            if (wr_eic) begin
                pending_rate_ff <= i_wdata[`BERT_RATE_MSB:`BERT_RATE_LSB];
            end
            if (active_rate_ff == 3'h0) begin
                if (wr_eic) begin
                    // Idle: a nonzero write starts a fresh interval at once
                    active_rate_ff <= i_wdata[`BERT_RATE_MSB:`BERT_RATE_LSB];
                    interval_cnt_ff <= {INTERVAL_W{1'b0}};
                end
            end else if (advance) begin
                if (rate_hit) begin
                    // New rate only takes effect after the pending error
                    active_rate_ff <= wr_eic ?
                        i_wdata[`BERT_RATE_MSB:`BERT_RATE_LSB] : pending_rate_ff;
                    interval_cnt_ff <= {INTERVAL_W{1'b0}};
                end else begin
                    interval_cnt_ff <= interval_cnt_ff + {{(INTERVAL_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // ==========================================================
    // Single-error insertion
    reg trigger_d_ff;
    reg single_pending_ff;
    wire trigger;
    wire trigger_rise;
    wire single_hit;

    // A source switch while a trigger is high can look like a rise
    assign trigger = insert_source_select_ff ?
        i_ext_error_insert_in : soft_error_insert_ff;
    assign trigger_rise = trigger & ~trigger_d_ff;
    assign single_hit = single_pending_ff & single_error_enable_ff;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trigger_d_ff <= 1'b0;
            single_pending_ff <= 1'b0;
        end else begin
            trigger_d_ff <= trigger;
            if (!single_error_enable_ff) begin
                single_pending_ff <= 1'b0;
            end else if (trigger_rise) begin
                // Extra rises before the next slot merge into one
                single_pending_ff <= 1'b1;
            end else if (advance) begin
                single_pending_ff <= 1'b0;
            end
        end
    end

    // Both sources landing on one bit still give one inversion
    assign tx_err = rate_hit | single_hit;
    assign tx_bit = gen_bit ^ tx_err;

    // ==========================================================
    // Receive status capture
    reg bit_error_ff;
    reg count_nonzero_ff;
    reg count_nonzero_d_ff;
    reg out_of_sync_ff;
    reg out_of_sync_d_ff;
    reg update_complete_ff;
    reg monitor_update_done_ff;
    reg done_d_ff;
    wire update_request;
    wire monitor_update_done;

    assign update_request = i_update_source_mode ?
        i_ext_monitor_update_in : i_local_monitor_update;
    // Request low masks the flag in the same cycle, not one later
    assign monitor_update_done = monitor_update_done_ff & update_request;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_error_ff <= 1'b0;
            count_nonzero_ff <= 1'b0;
            count_nonzero_d_ff <= 1'b0;
            out_of_sync_ff <= 1'b0;
            out_of_sync_d_ff <= 1'b0;
            update_complete_ff <= 1'b0;
            monitor_update_done_ff <= 1'b0;
            done_d_ff <= 1'b0;
        end else begin
            bit_error_ff <= i_rx_bit_error;
            count_nonzero_ff <= i_error_count_nonzero;
            out_of_sync_ff <= i_out_of_sync;
            update_complete_ff <= i_monitor_update_complete;
            count_nonzero_d_ff <= count_nonzero_ff;
            out_of_sync_d_ff <= out_of_sync_ff;
            done_d_ff <= monitor_update_done;
            if (!update_request) begin
                monitor_update_done_ff <= 1'b0;
            end else if (update_complete_ff) begin
                monitor_update_done_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Latched status, cleared by a read; a new event beats the clear
    reg [3:0] latched_ff;
    wire [3:0] latched_set;
    wire rd_latched;
    wire [7:0] live_status;

    assign rd_latched = i_rd_en && (i_addr == `BERT_ADDR_LATCHED);
    assign latched_set[`BERT_ST_UPDATE_BIT] = monitor_update_done & ~done_d_ff;
    assign latched_set[`BERT_ST_BITERR_BIT] = bit_error_ff;
    assign latched_set[`BERT_ST_COUNT_BIT] = count_nonzero_ff & ~count_nonzero_d_ff;
    assign latched_set[`BERT_ST_SYNC_BIT] = out_of_sync_ff ^ out_of_sync_d_ff;

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latched_ff <= 4'h0;
        end else begin
            latched_ff <= (latched_ff & {4{~rd_latched}}) | latched_set;
        end
    end

    assign live_status = {4'h0, monitor_update_done, 1'b0,
                          count_nonzero_ff, out_of_sync_ff};

    // ==========================================================
    // Read port; unmapped offsets read zero
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata_ff <= `BERT_REG_RESET;
        end else if (i_rd_en) begin
            case (i_addr)
                `BERT_ADDR_TAP: o_rdata_ff <= {3'h0, tap_select_field_ff};
                `BERT_ADDR_SEED0: o_rdata_ff <= seed_pattern_byte0_ff;
                `BERT_ADDR_SEED1: o_rdata_ff <= seed_pattern_byte1_ff;
                `BERT_ADDR_SEED2: o_rdata_ff <= seed_pattern_byte2_ff;
                `BERT_ADDR_SEED3: o_rdata_ff <= seed_pattern_byte3_ff;
                `BERT_ADDR_EIC: begin
                    o_rdata_ff <= {2'h0, error_rate_exponent_ff, single_error_enable_ff,
                                   soft_error_insert_ff, insert_source_select_ff};
                end
                `BERT_ADDR_LIVE: o_rdata_ff <= live_status;
                `BERT_ADDR_LATCHED: o_rdata_ff <= {4'h0, latched_ff};
                default: o_rdata_ff <= 8'h00;
            endcase
        end
    end

endmodule

// ==== bert_pattern_error_status_props.sv ====
`timescale 1ns/100ps
`include "bert_consts.vh"

// ==========================================================
// Port-level checker
module bert_pattern_error_status_props #(
    parameter SEED_W = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [4:0] i_addr,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata_ff,
    input wire i_update_source_mode,
    input wire i_local_monitor_update,
    input wire i_error_count_nonzero,
    input wire i_out_of_sync,
    input wire i_tx_bit_en,
    input wire i_tx_ready,
    input wire o_tx_valid,
    input wire o_tx_data,
    input wire o_tx_error_marked,
    input wire [SEED_W-1:0] o_seed_pattern_word,
    input wire [4:0] o_tap_select_field
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_tap_write:
        assert property (i_wr_en && i_addr == `BERT_ADDR_TAP
            |=> o_tap_select_field == $past(i_wdata[4:0])) else $error("tap field mismatch");
    a_seed_top:
        assert property (i_wr_en && i_addr == `BERT_ADDR_SEED3
            |=> o_seed_pattern_word[31:24] == $past(i_wdata)) else $error("seed top byte");
    a_seed_low:
        assert property (i_wr_en && i_addr == `BERT_ADDR_SEED0
            |=> o_seed_pattern_word[7:0] == $past(i_wdata)) else $error("seed low byte");
    // Input must be steady across the registering stage for a fixed answer
    a_live_sync:
        assert property (i_rd_en && i_addr == `BERT_ADDR_LIVE && $stable(i_out_of_sync)
            && $past(i_rst_n) |=> o_rdata_ff[0] == $past(i_out_of_sync))
            else $error("live sync bit");
    a_live_count:
        assert property (i_rd_en && i_addr == `BERT_ADDR_LIVE && $stable(i_error_count_nonzero)
            && $past(i_rst_n) |=> o_rdata_ff[1] == $past(i_error_count_nonzero))
            else $error("live count bit");
    a_update_drop:
        assert property (i_rd_en && i_addr == `BERT_ADDR_LIVE && !i_update_source_mode
            && !i_local_monitor_update |=> !o_rdata_ff[3]) else $error("update done not low");
    a_unmapped_zero:
        assert property (i_rd_en && !(i_addr inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
            5'h08, 5'h0C, 5'h0E}) |=> o_rdata_ff == 8'h00) else $error("unmapped read");
    a_rdata_hold:
        assert property (!i_rd_en |=> $stable(o_rdata_ff)) else $error("read data moved");
    a_tx_hold:
        assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)
            && $stable(o_tx_error_marked)) else $error("tx word dropped in stall");
    a_tx_cause:
        assert property ($rose(o_tx_valid) |-> $past(i_tx_bit_en)) else $error("tx without slot");
endmodule

bind bert_pattern_error_status bert_pattern_error_status_props #(.SEED_W(SEED_W)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata_ff(o_rdata_ff),
    .i_update_source_mode(i_update_source_mode), .i_local_monitor_update(i_local_monitor_update),
    .i_error_count_nonzero(i_error_count_nonzero), .i_out_of_sync(i_out_of_sync),
    .i_tx_bit_en(i_tx_bit_en), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_error_marked(o_tx_error_marked),
    .o_seed_pattern_word(o_seed_pattern_word), .o_tap_select_field(o_tap_select_field));

// ==== tx_sink.sv ====
`timescale 1ns/100ps

// ==========================================================
// Line receiver: records every accepted bit, stalls on command
module tx_sink (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_stall,
    input wire i_valid,
    input wire i_data,
    input wire i_mark,
    output wire o_ready
);
    logic data_q [0:255];
    logic mark_q [0:255];
    int count = 0;

    assign o_ready = !i_stall;
    always @(posedge i_clk) begin
        if (i_rst_n && i_valid && o_ready) begin
            data_q[count] <= i_data;
            mark_q[count] <= i_mark;
            count <= count + 1;
        end
    end
endmodule

// ==== bert_pattern_error_status_tb_top.sv ====
`timescale 1ns/100ps
`include "bert_consts.vh"

module bert_pattern_error_status_tb_top;
    logic i_clk;
    logic i_rst_n = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_tx_pattern_load = 1'b0;
    logic i_update_source_mode = 1'b0;
    logic i_local_monitor_update = 1'b0;
    logic i_ext_monitor_update_in = 1'b0;
    logic i_monitor_update_complete = 1'b0;
    logic i_rx_bit_error = 1'b0;
    logic i_error_count_nonzero = 1'b0;
    logic i_out_of_sync = 1'b0;
    logic i_ext_error_insert_in = 1'b0;
    logic i_tx_bit_en = 1'b0;
    logic stall = 1'b0;
    logic pat_repetitive = 1'b1;
    logic [4:0] pat_len = 5'h1F;
    wire i_tx_ready;
    wire o_tx_valid;
    wire o_tx_data;
    wire o_tx_error_marked;
    wire [7:0] o_rdata_ff;
    wire [31:0] o_seed_pattern_word;
    wire [4:0] o_tap_select_field;
    logic [4:0] addrs [0:7] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0C, 5'h0E};
    int num_errors = 0;
    int n_checks = 0;
    int s;
    int k;

    // Length 32 repetitive pattern keeps every expectation except the first-bit check position-free
    bert_pattern_error_status DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata_ff(o_rdata_ff),
        .i_pattern_length(pat_len), .i_pattern_repetitive(pat_repetitive),
        .i_tx_pattern_load(i_tx_pattern_load), .i_update_source_mode(i_update_source_mode),
        .i_local_monitor_update(i_local_monitor_update),
        .i_ext_monitor_update_in(i_ext_monitor_update_in),
        .i_monitor_update_complete(i_monitor_update_complete), .i_rx_bit_error(i_rx_bit_error),
        .i_error_count_nonzero(i_error_count_nonzero), .i_out_of_sync(i_out_of_sync),
        .i_ext_error_insert_in(i_ext_error_insert_in), .i_tx_bit_en(i_tx_bit_en),
        .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
        .o_tx_error_marked(o_tx_error_marked), .o_seed_pattern_word(o_seed_pattern_word),
        .o_tap_select_field(o_tap_select_field));

    tx_sink sink (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_stall(stall), .i_valid(o_tx_valid),
        .i_data(o_tx_data), .i_mark(o_tx_error_marked), .o_ready(i_tx_ready));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // ==========================================================
    // Access tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        idle(1);
        i_addr = a;
        i_wdata = d;
        i_wr_en = 1'b1;
        idle(1);
        i_wr_en = 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        idle(1);
        i_addr = a;
        i_rd_en = 1'b1;
        idle(1);
        i_rd_en = 1'b0;
        chk(o_rdata_ff, exp);
    endtask

    task automatic send(input int n);
        int start;
        int t;
        start = sink.count;
        idle(1);
        i_tx_bit_en = 1'b1;
        idle(n);
        i_tx_bit_en = 1'b0;
        for (t = 0; t < 50 && sink.count != start + n; t++) idle(1);
        if (sink.count != start + n) begin
            num_errors++;
            $display("tx wait limit hit");
            summarize();
        end
    endtask

    // Expect a mark on every per-th bit, only among the first stop bits
    task automatic marks(input int st, input int n, input int per, input int stop);
        for (int j = 0; j < n; j++) chk(sink.mark_q[st + j], (j < stop && j % per == per - 1));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        idle(6);
        i_rst_n = 1'b1;
        for (k = 0; k < 8; k++) rd_chk(addrs[k], 8'h00);
        wr(`BERT_ADDR_TAP, 8'hFF);
        rd_chk(`BERT_ADDR_TAP, 8'h1F);
        chk(o_tap_select_field, 5'h1F);
        wr(`BERT_ADDR_EIC, 8'hC7);
        rd_chk(`BERT_ADDR_EIC, 8'h07);
        wr(`BERT_ADDR_EIC, 8'h01);
        wr(`BERT_ADDR_EIC, 8'h00);
        wr(5'h01, 8'hFF);
        rd_chk(5'h01, 8'h00);
        wr(`BERT_ADDR_LIVE, 8'hFF);
        rd_chk(`BERT_ADDR_LIVE, 8'h00);
        wr(`BERT_ADDR_SEED0, 8'h96);
        wr(`BERT_ADDR_SEED1, 8'h0F);
        wr(`BERT_ADDR_SEED2, 8'hC3);
        wr(`BERT_ADDR_SEED3, 8'hA5);
        rd_chk(`BERT_ADDR_SEED3, 8'hA5);
        chk(o_seed_pattern_word, 32'hA5C30F96);
        $display("test registers done");
        i_tx_pattern_load = 1'b1;
        idle(2);
        i_tx_pattern_load = 1'b0;
        send(40);
        chk(sink.data_q[0], 1'b1);
        stall = 1'b1;
        i_tx_bit_en = 1'b1;
        idle(5);
        i_tx_bit_en = 1'b0;
        chk(o_tx_valid, 1'b1);
        chk(sink.count, 40);
        stall = 1'b0;
        idle(4);
        chk(sink.count, 42);
        $display("test stream and stall done");
        s = sink.count;
        wr(`BERT_ADDR_EIC, 8'h08);
        send(35);
        wr(`BERT_ADDR_EIC, 8'h00);
        send(15);
        marks(s, 50, 10, 40);
        wr(`BERT_ADDR_EIC, 8'h04);
        wr(`BERT_ADDR_EIC, 8'h06);
        wr(`BERT_ADDR_EIC, 8'h04);
        wr(`BERT_ADDR_EIC, 8'h06);
        wr(`BERT_ADDR_EIC, 8'h04);
        s = sink.count;
        send(10);
        marks(s, 10, 1, 1);
        wr(`BERT_ADDR_EIC, 8'h00);
        wr(`BERT_ADDR_EIC, 8'h02);
        wr(`BERT_ADDR_EIC, 8'h00);
        s = sink.count;
        send(5);
        marks(s, 5, 1, 0);
        wr(`BERT_ADDR_EIC, 8'h05);
        wr(`BERT_ADDR_EIC, 8'h07);
        wr(`BERT_ADDR_EIC, 8'h05);
        s = sink.count;
        send(5);
        marks(s, 5, 1, 0);
        i_ext_error_insert_in = 1'b1;
        idle(2);
        i_ext_error_insert_in = 1'b0;
        s = sink.count;
        send(5);
        marks(s, 5, 1, 1);
        for (k = 32; k < sink.count; k++) begin
            chk(sink.data_q[k] ^ sink.mark_q[k], sink.data_q[k-32] ^ sink.mark_q[k-32]);
        end
        $display("test error insertion done");
        wr(`BERT_ADDR_TAP, 8'h05);
        pat_len = 5'h06;
        pat_repetitive = 1'b0;
        i_tx_pattern_load = 1'b1;
        idle(2);
        i_tx_pattern_load = 1'b0;
        s = sink.count;
        send(40);
        // Stage 7 shows seed bits 6..0 first, then b[t] = b[t-7] ^ b[t-6]
        for (k = s; k < s + 40; k++) begin
            if (k < s + 7) begin
                chk(sink.data_q[k], (8'h96 >> (s + 6 - k)) & 8'h01);
            end else begin
                chk(sink.data_q[k], sink.data_q[k-7] ^ sink.data_q[k-6]);
            end
        end
        $display("test prbs done");
        i_out_of_sync = 1'b1;
        i_error_count_nonzero = 1'b1;
        idle(3);
        rd_chk(`BERT_ADDR_LIVE, 8'h03);
        rd_chk(`BERT_ADDR_LATCHED, 8'h03);
        rd_chk(`BERT_ADDR_LATCHED, 8'h00);
        i_rx_bit_error = 1'b1;
        idle(1);
        i_rx_bit_error = 1'b0;
        idle(3);
        rd_chk(`BERT_ADDR_LATCHED, 8'h04);
        i_out_of_sync = 1'b0;
        idle(3);
        rd_chk(`BERT_ADDR_LATCHED, 8'h01);
        rd_chk(`BERT_ADDR_LIVE, 8'h02);
        i_local_monitor_update = 1'b1;
        idle(2);
        i_monitor_update_complete = 1'b1;
        idle(1);
        i_monitor_update_complete = 1'b0;
        idle(3);
        rd_chk(`BERT_ADDR_LIVE, 8'h0A);
        rd_chk(`BERT_ADDR_LATCHED, 8'h08);
        i_local_monitor_update = 1'b0;
        idle(1);
        rd_chk(`BERT_ADDR_LIVE, 8'h02);
        i_update_source_mode = 1'b1;
        i_ext_monitor_update_in = 1'b1;
        idle(2);
        i_monitor_update_complete = 1'b1;
        idle(1);
        i_monitor_update_complete = 1'b0;
        idle(3);
        rd_chk(`BERT_ADDR_LIVE, 8'h0A);
        i_ext_monitor_update_in = 1'b0;
        idle(1);
        rd_chk(`BERT_ADDR_LIVE, 8'h02);
        $display("test status done");
        summarize();
    end
endmodule
